// *** verilog/strap_config_defines.vh ***
// Constants for the strap configuration loader.
// Assumes a 25 MHz core clock; included by bare name.
`ifndef STRAP_CONFIG_DEFINES_VH
`define STRAP_CONFIG_DEFINES_VH

// ==========================================================
// Timing
`define CLK_PERIOD_NS        40
`define STRAP_SETTLE_NS      200
`define STRAP_SETTLE_CYCLES  ((`STRAP_SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// ==========================================================
// Field positions in the 12-bit decoded strap word
`define ADDR_LO_POS          0
`define ADDR_HI_POS          4
`define SER_CLK_EN_POS       5
`define TERM_SEL_POS         6
`define MGMT_SEL_POS         7
`define EEPROM_LO_POS        8
`define EEPROM_HI_POS        9
`define MODE_LO_POS          10
`define MODE_HI_POS          11

// ==========================================================
// Two-bit decode codes
`define CONN_GROUND          2'h0
`define CONN_STATUS1         2'h1
`define CONN_STATUS0         2'h2
`define CONN_IO_RAIL         2'h3

// ==========================================================
// Boot read start field and addresses
`define EEPROM_NONE          2'h0
`define EEPROM_AT_0          2'h1
`define EEPROM_AT_96         2'h2
`define EEPROM_AT_128        2'h3
`define EEPROM_ADDR_0        8'h00
`define EEPROM_ADDR_96       8'h60
`define EEPROM_ADDR_128      8'h80

// ==========================================================
// Operating mode codes (strap) and software mode field
`define MODE_SERIAL_FX       2'h0
`define MODE_GBIC_COPPER     2'h1
`define MODE_AUTO_SERIAL     2'h2
`define MODE_AUTO_BASEX      2'h3
`define SW_MODE_GBIC_COPPER  3'h1
`define SW_MODE_AUTO_SERIAL  3'h2

// ==========================================================
// Reset values
`define SW_MODE_RESET        3'h0
`define ADDR_RESET           5'h00

`endif

// *** verilog/strap_decode.v ***
// Decodes six strap pins from two samples taken with the status pins
// driven in opposite patterns. Pure combinational.
`timescale 1ns/100ps
`default_nettype none
`include "strap_config_defines.vh"

module strap_decode
#(
	parameter PINS = 6
)
(
	input  wire [PINS-1:0]   sample_a_i,
	input  wire [PINS-1:0]   sample_b_i,
	output wire [2*PINS-1:0] code_o
);

	// ==========================================================
	// Pin connection decode
	// Phase A drives status 1 high, phase B drives status 0 high
	function [1:0] pin_code;
		input a;
		input b;
		begin
			case ({b, a})
				2'h0:    pin_code = `CONN_GROUND;
				2'h1:    pin_code = `CONN_STATUS1;
				2'h2:    pin_code = `CONN_STATUS0;
				default: pin_code = `CONN_IO_RAIL;
			endcase
		end
	endfunction

	genvar g;
	generate
		for (g = 0; g < PINS; g = g + 1)
		begin : g_pin
			assign code_o[2*g+1:2*g] = pin_code(sample_a_i[g], sample_b_i[g]);
		end
	endgenerate

endmodule // strap_decode

`default_nettype wire

// *** verilog/reset_polarity_strap_config.v ***
// Strap configuration loader: reset polarity, strap sampling, decode.
// Assumes strap and reset pins synchronous to clk_i; board pull-up
// on the polarity strap is reported through a driven flag.
`timescale 1ns/100ps
`default_nettype none
`include "strap_config_defines.vh"

module reset_polarity_strap_config
#(
	parameter PINS     = 6,
	parameter CNT_W    = 4,
	parameter SETTLE   = `STRAP_SETTLE_CYCLES
)
(
	input  wire            clk_i,
	input  wire            rst_n_i,
	input  wire            reset_pin_i,
	input  wire            reset_polarity_strap_i,
	input  wire            reset_polarity_strap_driven_i,
	input  wire [PINS-1:0] strap_pin_i,
	input  wire [1:0]      status_value_i,
	input  wire            sw_mode_write_i,
	input  wire [2:0]      sw_mode_data_i,
	input  wire            sw_clk_ctrl_write_i,
	input  wire            sw_clk_ctrl_data_i,
	output reg             device_reset_o,
	output reg             config_done_o,
	output reg  [1:0]      status_o,
	output reg  [1:0]      status_oe_o,
	output reg  [4:0]      management_address_field_o,
	output reg             serial_clock_output_pair_en_o,
	output reg             serial_clock_ctrl_o,
	output reg             management_port_select_o,
	output reg             termination_supply_select_o,
	output reg             termination_regulator_en_o,
	output reg  [1:0]      eeprom_start_field_o,
	output reg             eeprom_read_en_o,
	output reg  [7:0]      eeprom_start_addr_o,
	output reg  [1:0]      mode_strap_o,
	output reg  [2:0]      mode_select_o
);

	// ==========================================================
	// States
	localparam [2:0] ST_HOLD    = 3'h0;
	localparam [2:0] ST_DRIVE_A = 3'h1;
	localparam [2:0] ST_DRIVE_B = 3'h2;
	localparam [2:0] ST_APPLY   = 3'h3;
	localparam [2:0] ST_RUN     = 3'h4;

	localparam integer     SETTLE_LAST_I = SETTLE - 1;
	localparam [CNT_W-1:0] SETTLE_LAST   = SETTLE_LAST_I[CNT_W-1:0];

	// ==========================================================
	// Boot address lookup
	function [7:0] eeprom_addr;
		input [1:0] field;
		begin
			case (field)
				`EEPROM_AT_0:   eeprom_addr = `EEPROM_ADDR_0;
				`EEPROM_AT_96:  eeprom_addr = `EEPROM_ADDR_96;
				`EEPROM_AT_128: eeprom_addr = `EEPROM_ADDR_128;
				default:        eeprom_addr = `EEPROM_ADDR_0;
			endcase
		end
	endfunction

	// ==========================================================
	// Reset polarity
	wire polarity_high;
	wire reset_active;

	assign polarity_high = reset_polarity_strap_i | ~reset_polarity_strap_driven_i;
	assign reset_active  = ~(reset_pin_i ^ polarity_high);

	// ==========================================================
	// Sequencer state
	reg [2:0]        state_reg;
	reg [2:0]        state_next;
	reg [CNT_W-1:0]  cnt_reg;
	reg [CNT_W-1:0]  cnt_next;
	reg [PINS-1:0]   sample_a_reg;
	reg [PINS-1:0]   sample_b_reg;
	wire [2*PINS-1:0] code;
	wire             settled;

	assign settled = (cnt_reg == SETTLE_LAST);

	strap_decode
	#(
		.PINS (PINS)
	)
	u_decode
	(
		.sample_a_i (sample_a_reg),
		.sample_b_i (sample_b_reg),
		.code_o     (code)
	);

	always @*
	begin
		state_next = state_reg;
		cnt_next   = cnt_reg;
		case (state_reg)
			ST_HOLD:
			begin
				cnt_next = {CNT_W{1'b0}};
				if (!reset_active)
					state_next = ST_DRIVE_A;
			end
			ST_DRIVE_A:
			begin
				cnt_next = settled ? {CNT_W{1'b0}} : cnt_reg + 1'b1;
				if (settled)
					state_next = ST_DRIVE_B;
			end
			ST_DRIVE_B:
			begin
				cnt_next = settled ? {CNT_W{1'b0}} : cnt_reg + 1'b1;
				if (settled)
					state_next = ST_APPLY;
			end
			ST_APPLY:
				state_next = ST_RUN;
			ST_RUN:
				state_next = ST_RUN;
			default:
				state_next = ST_HOLD;
		endcase
		// Documented reset restarts the whole capture
		if (reset_active)
			state_next = ST_HOLD;
	end

	always @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			state_reg    <= ST_HOLD;
			cnt_reg      <= {CNT_W{1'b0}};
			sample_a_reg <= {PINS{1'b0}};
			sample_b_reg <= {PINS{1'b0}};
		end
		else
		begin
			state_reg <= state_next;
			cnt_reg   <= cnt_next;
			// Sample at the end of each settle window only
			if (state_reg == ST_DRIVE_A && settled)
				sample_a_reg <= strap_pin_i;
			if (state_reg == ST_DRIVE_B && settled)
				sample_b_reg <= strap_pin_i;
		end
	end

	// ==========================================================
	// Status pin drive
	// Patterns are driven only while sampling so normal status
	// reporting is undisturbed afterwards.
	always @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			status_o    <= 2'h0;
			status_oe_o <= 2'h0;
		end
		else
		begin
			case (state_next)
				ST_DRIVE_A:
				begin
					status_o    <= 2'h2;
					status_oe_o <= 2'h3;
				end
				ST_DRIVE_B:
				begin
					status_o    <= 2'h1;
					status_oe_o <= 2'h3;
				end
				ST_RUN:
				begin
					status_o    <= status_value_i;
					status_oe_o <= 2'h3;
				end
				default:
				begin
					status_o    <= 2'h0;
					status_oe_o <= 2'h0;
				end
			endcase
		end
	end

	// ==========================================================
	// Captured configuration
	wire [1:0] mode_code;
	wire       clk_en_code;
	wire       sw_ok;

	assign mode_code   = code[`MODE_HI_POS:`MODE_LO_POS];
	assign clk_en_code = code[`SER_CLK_EN_POS];
	assign sw_ok       = (state_reg == ST_RUN);

	always @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			device_reset_o                <= 1'b1;
			config_done_o                 <= 1'b0;
			management_address_field_o    <= `ADDR_RESET;
			serial_clock_output_pair_en_o <= 1'b0;
			serial_clock_ctrl_o           <= 1'b0;
			management_port_select_o      <= 1'b0;
			termination_supply_select_o   <= 1'b0;
			termination_regulator_en_o    <= 1'b0;
			eeprom_start_field_o          <= `EEPROM_NONE;
			eeprom_read_en_o              <= 1'b0;
			eeprom_start_addr_o           <= `EEPROM_ADDR_0;
			mode_strap_o                  <= `MODE_SERIAL_FX;
			mode_select_o                 <= `SW_MODE_RESET;
		end
		else if (reset_active)
		begin
			device_reset_o <= 1'b1;
			config_done_o  <= 1'b0;
		end
		else if (state_reg == ST_APPLY)
		begin
			device_reset_o                <= 1'b0;
			config_done_o                 <= 1'b1;
			management_address_field_o    <= code[`ADDR_HI_POS:`ADDR_LO_POS];
			serial_clock_output_pair_en_o <= clk_en_code;
			serial_clock_ctrl_o           <= clk_en_code;
			management_port_select_o      <= code[`MGMT_SEL_POS];
			termination_supply_select_o   <= code[`TERM_SEL_POS];
			termination_regulator_en_o    <= ~code[`TERM_SEL_POS];
			eeprom_start_field_o          <= code[`EEPROM_HI_POS:`EEPROM_LO_POS];
			eeprom_read_en_o              <= (code[`EEPROM_HI_POS:`EEPROM_LO_POS] != `EEPROM_NONE);
			eeprom_start_addr_o           <= eeprom_addr(code[`EEPROM_HI_POS:`EEPROM_LO_POS]);
			mode_strap_o                  <= mode_code;
			mode_select_o                 <= {1'b0, mode_code};
		end
		else if (sw_ok)
		begin
			// Writes before configuration completes are ignored
			if (sw_mode_write_i)
				mode_select_o <= sw_mode_data_i;
			if (sw_clk_ctrl_write_i)
			begin
				serial_clock_ctrl_o           <= sw_clk_ctrl_data_i;
				serial_clock_output_pair_en_o <= sw_clk_ctrl_data_i;
			end
		end
	end

endmodule // reset_polarity_strap_config

`default_nettype wire

// *** sim/strap_config_monitor.sv ***
// Port checker for the strap configuration loader.
// Assumes one clock domain; bound to every loader instance.
`timescale 1ns/100ps
`default_nettype none
// ==========================================
// Checker
module strap_config_monitor
(
	input wire       clk_i,
	input wire       rst_n_i,
	input wire       reset_pin_i,
	input wire       reset_polarity_strap_i,
	input wire       reset_polarity_strap_driven_i,
	input wire       sw_mode_write_i,
	input wire [2:0] sw_mode_data_i,
	input wire       device_reset_o,
	input wire       config_done_o,
	input wire [1:0] status_oe_o,
	input wire [4:0] management_address_field_o,
	input wire       termination_supply_select_o,
	input wire       termination_regulator_en_o,
	input wire [1:0] eeprom_start_field_o,
	input wire       eeprom_read_en_o,
	input wire [7:0] eeprom_start_addr_o,
	input wire [1:0] mode_strap_o,
	input wire [2:0] mode_select_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	// Floating strap counts as high
	wire act = ~(reset_pin_i ^ (reset_polarity_strap_i | ~reset_polarity_strap_driven_i));
	wire [1:0] ef = eeprom_start_field_o;
	property p_rst; act |=> device_reset_o && !config_done_o && status_oe_o == 2'h0; endproperty
	a_rst: assert property (p_rst) else $error("reset not obeyed");
	property p_done; config_done_o |-> !device_reset_o; endproperty
	a_done: assert property (p_done) else $error("done while in reset");
	property p_rd; config_done_o |-> eeprom_read_en_o == (ef != 2'h0); endproperty
	a_rd: assert property (p_rd) else $error("boot read enable wrong");
	property p_addr;
		config_done_o |-> eeprom_start_addr_o == (ef == 2'h3 ? 8'h80 : ef == 2'h2 ? 8'h60 : 8'h00);
	endproperty
	a_addr: assert property (p_addr) else $error("boot address wrong");
	property p_term; config_done_o |-> termination_regulator_en_o != termination_supply_select_o;
	endproperty
	a_term: assert property (p_term) else $error("regulator enable wrong");
	property p_hold; config_done_o && $past(config_done_o)
		|-> $stable({management_address_field_o, ef, mode_strap_o}); endproperty
	a_hold: assert property (p_hold) else $error("captured straps moved");
	property p_mode; $rose(config_done_o) |-> mode_select_o == {1'b0, mode_strap_o}; endproperty
	a_mode: assert property (p_mode) else $error("mode default wrong");
	property p_sw; config_done_o && !act && sw_mode_write_i |=> mode_select_o == $past(sw_mode_data_i);
	endproperty
	a_sw: assert property (p_sw) else $error("mode write lost");
	c_done: cover property ($rose(config_done_o));
	c_sw: cover property (config_done_o && sw_mode_write_i);
	c_act: cover property (act && config_done_o);
endmodule // strap_config_monitor
bind reset_polarity_strap_config strap_config_monitor u_mon
(
	.clk_i(clk_i), .rst_n_i(rst_n_i), .reset_pin_i(reset_pin_i),
	.reset_polarity_strap_i(reset_polarity_strap_i),
	.reset_polarity_strap_driven_i(reset_polarity_strap_driven_i),
	.sw_mode_write_i(sw_mode_write_i), .sw_mode_data_i(sw_mode_data_i),
	.device_reset_o(device_reset_o), .config_done_o(config_done_o), .status_oe_o(status_oe_o),
	.management_address_field_o(management_address_field_o),
	.termination_supply_select_o(termination_supply_select_o),
	.termination_regulator_en_o(termination_regulator_en_o),
	.eeprom_start_field_o(eeprom_start_field_o), .eeprom_read_en_o(eeprom_read_en_o),
	.eeprom_start_addr_o(eeprom_start_addr_o), .mode_strap_o(mode_strap_o),
	.mode_select_o(mode_select_o)
);
`default_nettype wire

// *** sim/strap_board_model.sv ***
// Board strap wiring: each pin tied to ground, a status pin or the rail.
// Assumes conn_i holds the two-bit connection code of each pin.
`timescale 1ns/100ps
`default_nettype none
// ==========================================
// Board model
module strap_board_model
(
	input  wire        clk_i,
	input  wire [1:0]  status_i,
	input  wire [1:0]  status_oe_i,
	input  wire [11:0] conn_i,
	output reg  [5:0]  strap_o
);
	// Undriven status line toggles: no stale level to hide behind
	reg tog = 1'b0;
	wire [1:0] lvl = {status_oe_i[1] ? status_i[1] : tog, status_oe_i[0] ? status_i[0] : tog};
	integer k;
	always @(posedge clk_i)
		tog <= ~tog;
	always @*
		for (k = 0; k < 6; k = k + 1)
			case (conn_i[2*k +: 2])
			2'h0: strap_o[k] = 1'b0;
			2'h1: strap_o[k] = lvl[1];
			2'h2: strap_o[k] = lvl[0];
			default: strap_o[k] = 1'b1;
			endcase
endmodule // strap_board_model
`default_nettype wire

// *** sim/testbench.sv ***
// Self-checking bench for the strap configuration loader.
// Assumes a 25 MHz clock and the board model on the strap pins.
`timescale 1ns/100ps
`default_nettype none
`include "strap_config_defines.vh"
// ==========================================
// Bench
module testbench;
	reg clk_i = 0, rst_n_i = 0, pin = 1, pol = 0, drv = 1, mw = 0, cw = 0, cd = 0;
	reg [2:0] md = 0;
	reg [11:0] conn = 0;
	reg [1:0] sv = 2'h1;
	wire [5:0] strap;
	wire [1:0] st, oe, ef, ms;
	wire [4:0] adr;
	wire [7:0] ea;
	wire [2:0] msel;
	wire dr, dn, sce, scc, mps, tss, tre, ere;
	integer err_total = 0, tests_run = 0;
	reset_polarity_strap_config u_dut
	(
		.clk_i(clk_i), .rst_n_i(rst_n_i), .reset_pin_i(pin), .reset_polarity_strap_i(pol),
		.reset_polarity_strap_driven_i(drv), .strap_pin_i(strap), .status_value_i(sv),
		.sw_mode_write_i(mw), .sw_mode_data_i(md), .sw_clk_ctrl_write_i(cw),
		.sw_clk_ctrl_data_i(cd), .device_reset_o(dr), .config_done_o(dn), .status_o(st),
		.status_oe_o(oe), .management_address_field_o(adr), .serial_clock_output_pair_en_o(sce),
		.serial_clock_ctrl_o(scc), .management_port_select_o(mps),
		.termination_supply_select_o(tss), .termination_regulator_en_o(tre),
		.eeprom_start_field_o(ef), .eeprom_read_en_o(ere), .eeprom_start_addr_o(ea),
		.mode_strap_o(ms), .mode_select_o(msel)
	);
	strap_board_model u_board
	(
		.clk_i(clk_i), .status_i(st), .status_oe_i(oe), .conn_i(conn), .strap_o(strap)
	);
	initial
	begin
		forever #20 clk_i = ~clk_i;
	end
	task cyc(input integer n);
	begin
		repeat (n) @(posedge clk_i);
		#2;
	end
	endtask
	task chk(input [63:0] nm, input [11:0] ex, input [11:0] got);
	begin
		tests_run = tests_run + 1;
		if (got !== ex)
		begin
			err_total = err_total + 1;
			$display("ERROR %0s expected %h seen %h", nm, ex, got);
		end
	end
	endtask
	// Reset, refused write during hold, then every decoded field
	task t_cfg(input p, input d, input [11:0] c);
		integer n;
	begin
		pol = p;
		drv = d;
		conn = c;
		sv = c[1:0];
		pin = p | ~d;
		cyc(1);
		md = 3'h7;
		mw = 1;
		cyc(1);
		mw = 0;
		cyc(2);
		chk("drst", 1, dr);
		chk("done0", 0, dn);
		chk("oe0", 0, oe);
		pin = ~pin;
		n = 0;
		while (dn !== 1'b1 && n < 40)
		begin
			cyc(1);
			n = n + 1;
		end
		// One hold exit cycle, two settle windows, one apply cycle, counted from the release
		chk("lat", 2 * `STRAP_SETTLE_CYCLES + 2, n);
		chk("drst1", 0, dr);
		chk("adr", c[4:0], adr);
		chk("sclk", c[5], sce);
		chk("sctl", c[5], scc);
		chk("term", c[6], tss);
		chk("treg", !c[6], tre);
		chk("mgmt", c[7], mps);
		chk("eef", c[9:8], ef);
		chk("eerd", c[9:8] != 0, ere);
		chk("eea", c[9:8] == 3 ? 8'h80 : c[9:8] == 2 ? 8'h60 : 8'h00, ea);
		chk("mode", c[11:10], ms);
		chk("msel", {1'b0, c[11:10]}, msel);
		chk("stat", sv, st);
		chk("stoe", 2'h3, oe);
	end
	endtask
	// Straps rewired after capture must not matter
	task t_hold;
		reg [11:0] c;
	begin
		c = conn;
		conn = ~conn;
		sv = ~sv;
		cyc(30);
		chk("hadr", c[4:0], adr);
		chk("hmode", c[11:10], ms);
		chk("hstat", sv, st);
		conn = c;
	end
	endtask
	// Back-to-back software writes
	task t_sw;
	begin
		md = 3'h2;
		mw = 1;
		cyc(1);
		chk("sw0", 3'h2, msel);
		md = 3'h1;
		cd = ~scc;
		cw = 1;
		cyc(1);
		mw = 0;
		cw = 0;
		cyc(1);
		chk("sw1", 3'h1, msel);
		chk("swc", cd, scc);
		chk("swe", cd, sce);
	end
	endtask
	task summarize;
	begin
		if (err_total == 0 && tests_run > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	end
	endtask
	initial
	begin
		cyc(16);
		rst_n_i = 1;
		cyc(2);
		t_cfg(0, 1, 12'h000);
		t_cfg(1, 1, 12'h555);
		t_hold;
		t_cfg(0, 0, 12'haaa);
		t_sw;
		t_cfg(1, 0, 12'hfff);
		t_sw;
		rst_n_i = 0;
		cyc(2);
		chk("por", 1, dr);
		chk("pordn", 0, dn);
		rst_n_i = 1;
		t_cfg(0, 1, 12'he4b);
		summarize;
	end
	// Whole run is well under 1000 cycles
	initial
	begin
		#100000;
		err_total = err_total + 1;
		summarize;
	end
endmodule // testbench
`default_nettype wire
